/* verilog/mst_modem_status.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - data ready shows received characters held
// - four change bits set on input change
// - status read clears change bits
// - bit 7 is inverted carrier pin
// - loop-back: bit 7 follows aux two
// - bit 6 ring, loop-back aux one
// - bit 5 data-set-ready, loop-back DTR
// - bit 4 clear-to-send, loop-back RTS
// - auto flow stops transmit, pin high, loop-back RTS clear
// - carrier, dsr, cts changes either direction
// - ring change only on falling ring bit (pin rising)
// - any change bit raises modem irq
// - eight-bit scratch register for software
module mst_modem_status
    import mst_pkg::*;
#(
    parameter int unsigned AW = MST_AW,
    parameter int unsigned DW = MST_DW
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic dcd_n,
    input wire logic ri_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic rx_char_held,
    input wire logic tx_char_done,
    output logic dtr_n,
    output logic rts_n,
    output logic aux_output_one_n,
    output logic aux_output_two_n,
    output logic loopback,
    output logic tx_allowed,
    output logic modem_irq,
    output logic irq
);
    logic [3:0] pins_s;
    logic [3:0] live;
    logic [3:0] live_r;
    logic live_vld_r;
    logic [3:0] delta_r;
    logic [3:0] delta_set;
    logic [7:0] modem_control_reg_r;
    logic [7:0] enhanced_feature_reg_r;
    logic [7:0] scratch_reg_r;
    logic [MST_IRQ_W-1:0] irq_stat_r;
    logic [MST_IRQ_W-1:0] irq_mask_r;
    logic [MST_IRQ_W-1:0] irq_ev;
    logic rx_held_r;
    logic tx_hold_r;
    logic [7:0] modem_status_reg;
    logic [7:0] line_status_reg;
    logic rd_modem;
    logic lb;

    function automatic logic hit(input logic [AW-1:0] a, input logic [3:0] off);
        hit = (a == AW'(off));
    endfunction

    mst_sync #(
        .W(4),
        .INIT(MST_PIN_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({dcd_n, ri_n, dsr_n, cts_n}),
        .q(pins_s)
    );

    assign lb = modem_control_reg_r[MST_MC_LOOP];
    assign rd_modem = reg_rd && hit(reg_addr, MST_OFF_MODEM_STATUS);

    // live status order: dcd, ri, dsr, cts
    always_comb begin
        if (lb) begin
            live[3] = modem_control_reg_r[MST_MC_OUT_TWO];
            live[2] = modem_control_reg_r[MST_MC_OUT_ONE];
            live[1] = modem_control_reg_r[MST_MC_DTR];
            live[0] = modem_control_reg_r[MST_MC_RTS];
        end else begin
            // inverted pins, also ring dsr cts
            live = ~pins_s;
        end
    end

    // previous live value; edge detection idle until first sample
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            live_r <= MST_NIB_ZERO;
            live_vld_r <= 1'b0;
        end else begin
            live_r <= live;
            live_vld_r <= 1'b1;
        end
    end

    always_comb begin
        delta_set = MST_NIB_ZERO;
        if (live_vld_r) begin
            delta_set[3] = live[3] ^ live_r[3];
            delta_set[1] = live[1] ^ live_r[1];
            delta_set[0] = live[0] ^ live_r[0];
            // ring status falls when pin rises
            delta_set[2] = live_r[2] & ~live[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            delta_r <= MST_NIB_ZERO;
        end else begin
            delta_r <= (rd_modem ? MST_NIB_ZERO : delta_r) | delta_set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_held_r <= 1'b0;
        end else begin
            rx_held_r <= rx_char_held;
        end
    end

    assign modem_status_reg = {live, delta_r};
    always_comb begin
        line_status_reg = MST_BYTE_ZERO;
        line_status_reg[MST_LS_DATA_READY] = rx_char_held;
    end

    // register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            modem_control_reg_r <= MST_BYTE_ZERO;
            enhanced_feature_reg_r <= MST_BYTE_ZERO;
            irq_mask_r <= MST_IRQ_ZERO;
        end else if (reg_wr) begin
            if (hit(reg_addr, MST_OFF_MODEM_CONTROL)) begin
                modem_control_reg_r <= reg_wdata;
            end
            if (hit(reg_addr, MST_OFF_ENH_FEATURE)) begin
                enhanced_feature_reg_r <= reg_wdata;
            end
            if (hit(reg_addr, MST_OFF_IRQ_MASK)) begin
                irq_mask_r <= reg_wdata[MST_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scratch_reg_r <= MST_BYTE_ZERO;
        end else if (reg_wr && hit(reg_addr, MST_OFF_SCRATCH)) begin
            scratch_reg_r <= reg_wdata;
        end
    end

    // interrupt status: modem change, data ready rising
    always_comb begin
        irq_ev = MST_IRQ_ZERO;
        irq_ev[MST_IRQ_MODEM] = |delta_set;
        irq_ev[MST_IRQ_DATA] = rx_char_held & ~rx_held_r;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_stat_r <= MST_IRQ_ZERO;
        end else if (reg_wr && hit(reg_addr, MST_OFF_IRQ_STATUS)) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[MST_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    // read data, one cycle after strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= MST_BYTE_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                AW'(MST_OFF_LINE_STATUS): reg_rdata <= line_status_reg;
                AW'(MST_OFF_MODEM_STATUS): reg_rdata <= modem_status_reg;
                AW'(MST_OFF_SCRATCH): reg_rdata <= scratch_reg_r;
                AW'(MST_OFF_MODEM_CONTROL): reg_rdata <= modem_control_reg_r;
                AW'(MST_OFF_ENH_FEATURE): reg_rdata <= enhanced_feature_reg_r;
                AW'(MST_OFF_IRQ_STATUS): reg_rdata <= {6'h00, irq_stat_r};
                AW'(MST_OFF_IRQ_MASK): reg_rdata <= {6'h00, irq_mask_r};
                default: reg_rdata <= MST_BYTE_ZERO;
            endcase
        end else begin
            reg_rdata <= MST_BYTE_ZERO;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_hold_r <= 1'b0;
        end else if (!enhanced_feature_reg_r[MST_EF_AUTO_CTS]) begin
            tx_hold_r <= 1'b0;
        end else if (!live[0]) begin
            if (tx_char_done || !tx_hold_r) begin
                tx_hold_r <= 1'b1;
            end
        end else begin
            tx_hold_r <= 1'b0;
        end
    end

    assign tx_allowed = ~tx_hold_r;

    // modem outputs, inactive in loop-back
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            aux_output_one_n <= 1'b1;
            aux_output_two_n <= 1'b1;
            loopback <= 1'b0;
        end else begin
            dtr_n <= lb | ~modem_control_reg_r[MST_MC_DTR];
            rts_n <= lb | ~modem_control_reg_r[MST_MC_RTS];
            aux_output_one_n <= lb | ~modem_control_reg_r[MST_MC_OUT_ONE];
            aux_output_two_n <= lb | ~modem_control_reg_r[MST_MC_OUT_TWO];
            loopback <= lb;
        end
    end

    assign modem_irq = |delta_r;
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

/* verilog/mst_pkg.sv */
package mst_pkg;
    localparam int unsigned MST_AW = 4;
    localparam int unsigned MST_DW = 8;
    // register offsets
    localparam logic [3:0] MST_OFF_LINE_STATUS = 4'h5;
    localparam logic [3:0] MST_OFF_MODEM_STATUS = 4'h6;
    localparam logic [3:0] MST_OFF_SCRATCH = 4'h7;
    localparam logic [3:0] MST_OFF_MODEM_CONTROL = 4'h4;
    localparam logic [3:0] MST_OFF_ENH_FEATURE = 4'h2;
    localparam logic [3:0] MST_OFF_IRQ_STATUS = 4'h8;
    localparam logic [3:0] MST_OFF_IRQ_MASK = 4'h9;
    // modem status field positions
    localparam int unsigned MST_MS_DCD = 7;
    localparam int unsigned MST_MS_RI = 6;
    localparam int unsigned MST_MS_DSR = 5;
    localparam int unsigned MST_MS_CTS = 4;
    localparam int unsigned MST_MS_DDCD = 3;
    localparam int unsigned MST_MS_TERI = 2;
    localparam int unsigned MST_MS_DDSR = 1;
    localparam int unsigned MST_MS_DCTS = 0;
    // modem control field positions
    localparam int unsigned MST_MC_DTR = 0;
    localparam int unsigned MST_MC_RTS = 1;
    localparam int unsigned MST_MC_OUT_ONE = 2;
    localparam int unsigned MST_MC_OUT_TWO = 3;
    localparam int unsigned MST_MC_LOOP = 4;
    // enhanced feature field
    localparam int unsigned MST_EF_AUTO_CTS = 7;
    // line status field
    localparam int unsigned MST_LS_DATA_READY = 0;
    // irq status bits
    localparam int unsigned MST_IRQ_MODEM = 0;
    localparam int unsigned MST_IRQ_DATA = 1;
    localparam int unsigned MST_IRQ_W = 2;
    localparam logic [7:0] MST_BYTE_ZERO = 8'h00;
    localparam logic [3:0] MST_NIB_ZERO = 4'h0;
    localparam logic [1:0] MST_PAIR_ZERO = 2'h0;
    localparam logic [MST_IRQ_W-1:0] MST_IRQ_ZERO = 2'h0;
    // pins idle high (inactive) after reset
    localparam logic [3:0] MST_PIN_IDLE = 4'hf;
endpackage

/* verilog/mst_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, vector wide
module mst_sync
    import mst_pkg::*;
#(
    parameter int unsigned W = 4,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* tb/mst_modem_status_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_modem_status_asserts
    import mst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic dcd_n,
    input wire logic ri_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic rx_char_held,
    input wire logic loopback,
    input wire logic tx_allowed,
    input wire logic modem_irq
);
    logic auto_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            auto_r <= 1'b0;
        end else if (reg_wr && reg_addr == MST_OFF_ENH_FEATURE) begin
            auto_r <= reg_wdata[MST_EF_AUTO_CTS];
        end
    end
    sequence quiet_s;
        (!loopback && $stable({dcd_n, ri_n, dsr_n, cts_n}))[*4];
    endsequence
    sequence scr_s;
        (reg_wr && reg_addr == MST_OFF_SCRATCH) ##1 (reg_rd && reg_addr == MST_OFF_SCRATCH);
    endsequence
    property chg_p(ev);
        (ev && !loopback) |-> ##[1:5] modem_irq;
    endproperty
    read_clear_a: assert property (quiet_s ##0 (reg_rd && reg_addr == MST_OFF_MODEM_STATUS) |=> !modem_irq)
        else $error("change bits kept after read");
    dcd_change_a: assert property (chg_p($changed(dcd_n)))
        else $error("carrier change missed");
    dsr_change_a: assert property (chg_p($changed(dsr_n)))
        else $error("data set change missed");
    cts_change_a: assert property (chg_p($changed(cts_n)))
        else $error("clear to send change missed");
    ring_rise_a: assert property (chg_p($rose(ri_n)))
        else $error("ring change missed");
    scratch_rd_a: assert property (scr_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("scratch value lost");
    ready_rd_a: assert property (reg_rd && reg_addr == MST_OFF_LINE_STATUS |=> reg_rdata == {7'h00, $past(rx_char_held)})
        else $error("data ready wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == MST_BYTE_ZERO)
        else $error("read data outside read");
    flow_stop_a: assert property ((auto_r && cts_n && !loopback)[*5] |-> !tx_allowed)
        else $error("transmit not held");
    flow_go_a: assert property ((!cts_n && !loopback)[*5] |-> tx_allowed)
        else $error("transmit not resumed");
endmodule
`default_nettype wire

/* tb/mst_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mst_modem_model (
    input wire logic clk_sys,
    input wire logic [3:0] want,
    output logic dcd_n,
    output logic ri_n,
    output logic dsr_n,
    output logic cts_n
);
    // lines idle high, move just after an edge
    initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
    always @(posedge clk_sys) begin
        {dcd_n, ri_n, dsr_n, cts_n} <= want;
    end
endmodule
`default_nettype wire

/* tb/tb_modem_status_tracker.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_modem_status_tracker
    import mst_pkg::*;
;
    logic clk_sys, rst, reg_wr, reg_rd, rx_char_held, tx_char_done, dcd_n, ri_n, dsr_n, cts_n;
    logic dtr_n, rts_n, ao1_n, ao2_n, loopback, tx_allowed, modem_irq, irq;
    logic [3:0] reg_addr, want;
    logic [7:0] reg_wdata, reg_rdata, v;
    int errors = 0;
    int n_tests = 0;
    mst_modem_status i_mst_modem_status (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dcd_n(dcd_n),
        .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .rx_char_held(rx_char_held), .tx_char_done(tx_char_done),
        .dtr_n(dtr_n), .rts_n(rts_n), .aux_output_one_n(ao1_n), .aux_output_two_n(ao2_n),
        .loopback(loopback), .tx_allowed(tx_allowed), .modem_irq(modem_irq), .irq(irq));
    mst_modem_model i_mst_modem_model (.clk_sys(clk_sys), .want(want), .dcd_n(dcd_n), .ri_n(ri_n),
        .dsr_n(dsr_n), .cts_n(cts_n));
    task automatic stop_test();
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #20000;
        errors++;
        stop_test();
    end
    initial begin
        {rst, reg_wr, reg_rd, rx_char_held, tx_char_done} = 5'h10;
        {reg_addr, reg_wdata, want} = 16'h000f;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(MST_OFF_MODEM_STATUS);
        `CHK("ms_reset", 8'h00, v)
        rx_char_held <= 1'b1;
        rd(MST_OFF_LINE_STATUS);
        `CHK("ls_ready", 8'h01, v)
        rx_char_held <= 1'b0;
        wr(MST_OFF_LINE_STATUS, 8'hff);
        rd(MST_OFF_LINE_STATUS);
        `CHK("ls_empty", 8'h00, v)
        wr(MST_OFF_IRQ_STATUS, 8'h03);
        wr(MST_OFF_IRQ_MASK, 8'h01);
        for (int i = 0; i < 4; i++) begin
            want <= ~(4'h1 << i);
            repeat (6) @(posedge clk_sys);
            `CHK("mirq", i != 2, modem_irq)
            `CHK("irq", i != 2, irq)
            if (i == 0) begin
                wr(MST_OFF_IRQ_MASK, 8'h00);
                `CHK("irq_masked", 1'b0, irq)
                wr(MST_OFF_IRQ_MASK, 8'h01);
            end
            rd(MST_OFF_MODEM_STATUS);
            `CHK("ms_on", {4'h1 << i, i == 2 ? 4'h0 : 4'h1 << i}, v)
            rd(MST_OFF_MODEM_STATUS);
            `CHK("ms_clr", {4'h1 << i, 4'h0}, v)
            want <= 4'hf;
            repeat (6) @(posedge clk_sys);
            rd(MST_OFF_MODEM_STATUS);
            `CHK("ms_off", {4'h0, 4'h1 << i}, v)
            wr(MST_OFF_IRQ_STATUS, 8'h01);
            `CHK("irq_clr", 1'b0, irq)
        end
        for (int i = 0; i < 4; i++) begin
            wr(MST_OFF_MODEM_CONTROL, 8'h10 | (8'h01 << i));
            rd(MST_OFF_MODEM_STATUS);
            `CHK("loop", (i < 2) ? (4'h2 >> i) : (4'h1 << i), v[7:4])
            `CHK("lb_out", 1'b1, loopback)
        end
        wr(MST_OFF_MODEM_CONTROL, 8'h0f);
        #1;
        `CHK("outs", 4'h0, {ao2_n, ao1_n, rts_n, dtr_n})
        `CHK("lb_off", 1'b0, loopback)
        wr(MST_OFF_MODEM_CONTROL, 8'h00);
        wr(MST_OFF_SCRATCH, 8'ha5);
        rd(MST_OFF_SCRATCH);
        `CHK("scratch", 8'ha5, v)
        rd(MST_OFF_SCRATCH);
        `CHK("scratch_again", 8'ha5, v)
        reg_wdata <= 8'h5a;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        rd(MST_OFF_SCRATCH);
        `CHK("scratch_b2b", 8'h5a, v)
        wr(4'hf, 8'hff);
        rd(4'hf);
        `CHK("unmapped", 8'h00, v)
        wr(MST_OFF_ENH_FEATURE, 8'h80);
        repeat (6) @(posedge clk_sys);
        `CHK("tx_hold", 1'b0, tx_allowed)
        tx_char_done <= 1'b1;
        want <= 4'he;
        @(posedge clk_sys);
        tx_char_done <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK("tx_go", 1'b1, tx_allowed)
        stop_test();
    end
endmodule
bind mst_modem_status mst_modem_status_asserts i_mst_modem_status_asserts (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dcd_n(dcd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .rx_char_held(rx_char_held),
    .loopback(loopback), .tx_allowed(tx_allowed), .modem_irq(modem_irq));
`default_nettype wire
